// ### ipf_top.v
// Purpose: Image port output formatter: packs video pairs into double words, serializes them with
//          timing codes, arbitrates against sliced text and drives the reference pins.
// Assumes: Video and text sources run on clk; port clock sources are asynchronous pins.
// Notes:   Port clocks are sampled by clk, so a usable port clock is below half the clk rate.
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
`include "ipf_regs.vh"

module ipf_top (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        ce,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        vid_valid,
   output reg         vid_ready,
   input  wire [7:0]  vid_y0,
   input  wire [7:0]  vid_y1,
   input  wire [7:0]  vid_cb,
   input  wire [7:0]  vid_cr,
   input  wire        vid_sol,
   input  wire        vid_eol,
   input  wire        vid_sof,
   input  wire        vid_field,
   input  wire        vid_vact,
   input  wire        txt_valid,
   input  wire [7:0]  txt_data,
   input  wire        txt_last,
   output reg         txt_ready,
   input  wire        decoder_clk_in,
   input  wire        xport_clk_in,
   input  wire        ext_clk_in,
   input  wire        transfer_ready_gate_in,
   output reg         port_clk_out,
   output reg  [7:0]  port_data,
   output reg  [7:0]  upper_byte_lane_pins,
   output reg         output_data_qualifier,
   output reg         line_active_reference,
   output reg         gp_pin0,
   output reg         gp_pin1
);

   // ----------------------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------------------
   function [7:0] clip8;
      input [7:0] b;
      input       lim;
      reg   [7:0] lo;
      reg   [7:0] hi;
      begin
         lo = lim ? `IPF_LIM1_LO : `IPF_LIM0_LO;
         hi = lim ? `IPF_LIM1_HI : `IPF_LIM0_HI;
         clip8 = (b < lo) ? lo : ((b > hi) ? hi : b);
      end
   endfunction

   function [7:0] code_byte;
      input eav;
      input vact;
      input field;
      input msb;
      begin
         case ({msb, !vact, eav, field})
            4'h0: code_byte = 8'h0E;
            4'h1: code_byte = 8'h49;
            4'h2: code_byte = 8'h13;
            4'h3: code_byte = 8'h54;
            4'h4: code_byte = 8'h25;
            4'h5: code_byte = 8'h62;
            4'h6: code_byte = 8'h38;
            4'h7: code_byte = 8'h7F;
            4'h8: code_byte = 8'h80;
            4'h9: code_byte = 8'hC7;
            4'hA: code_byte = 8'h9D;
            4'hB: code_byte = 8'hDA;
            4'hC: code_byte = 8'hAB;
            4'hD: code_byte = 8'hEC;
            4'hE: code_byte = 8'hB6;
            default: code_byte = 8'hF1;
         endcase
      end
   endfunction

   function ev_pick;
      input [3:0] sel;
      input [8:0] ev;
      begin
         ev_pick = (sel < `IPF_EV_COUNT) ? ev[sel] : 1'b0;
      end
   endfunction

   // ----------------------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------------------
   localparam ST_IDLE = 2'h0;
   localparam ST_CODE = 2'h1;
   localparam ST_VDAT = 2'h2;
   localparam ST_TDAT = 2'h3;

   reg  [31:0] ctrl_reg;
   reg  [31:0] pinmap_reg;
   reg  [1:0]  st_reg;
   reg         dw_full_reg;
   reg         half_v_reg;
   reg         sliced_reg;
   reg         field_ev_reg;
   reg         gate_s1_reg;
   reg         gate_s2_reg;

   wire [2:0]  horizontal_packing_select     = ctrl_reg[`IPF_CTRL_PACK_LSB +: 3];
   wire [1:0]  luma_only_line_count          = ctrl_reg[`IPF_CTRL_LINES_LSB +: 2];
   wire        skip_leading_luma_lines       = ctrl_reg[`IPF_CTRL_SKIP_BIT];
   wire        code_range_limit_select       = ctrl_reg[`IPF_CTRL_LIMIT_BIT];
   wire        wide_bus                      = ctrl_reg[`IPF_CTRL_WIDE_BIT];
   wire        codes_en                      = ctrl_reg[`IPF_CTRL_CODES_BIT];
   wire        programming_page_select       = ctrl_reg[`IPF_CTRL_PAGE_BIT];
   wire        text_video_arbitration_ctl_lo = ctrl_reg[`IPF_CTRL_ARBLO_BIT];
   wire        text_video_arbitration_ctl_hi = ctrl_reg[`IPF_CTRL_ARBHI_BIT];
   wire        gate_clk_mode                 = ctrl_reg[`IPF_CTRL_GATE_BIT];
   wire [1:0]  port_clk_select               = ctrl_reg[`IPF_CTRL_CSEL_LSB +: 2];
   wire        text_code_msb                 = ctrl_reg[`IPF_CTRL_TMSB_BIT];
   wire [1:0]  arb = {text_video_arbitration_ctl_hi, text_video_arbitration_ctl_lo};
   wire [3:0]  pol = pinmap_reg[`IPF_PIN_POL_LSB +: 4];
   wire        setup = psel && !penable;
   wire        hit = (paddr == `IPF_ADDR_CTRL) || (paddr == `IPF_ADDR_PINMAP) || (paddr == `IPF_ADDR_STATUS);

   always @(posedge clk) begin
      if (!rst_n) begin
         ctrl_reg   <= `IPF_CTRL_RST;
         pinmap_reg <= `IPF_PIN_RST;
         prdata     <= 32'h00000000;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
      end else if (ce) begin
         pready <= 1'b1;
         if (setup) begin
            pslverr <= !hit;
            if (paddr == `IPF_ADDR_CTRL)
               prdata <= ctrl_reg;
            else if (paddr == `IPF_ADDR_PINMAP)
               prdata <= pinmap_reg;
            else if (paddr == `IPF_ADDR_STATUS)
               prdata <= {24'h000000, gate_s2_reg, field_ev_reg, sliced_reg, half_v_reg, dw_full_reg, 1'b0, st_reg};
            else
               prdata <= 32'h00000000;
         end
         if (psel && penable && pready && pwrite) begin
            if (paddr == `IPF_ADDR_CTRL)
               ctrl_reg <= pwdata & `IPF_CTRL_MASK;
            else if (paddr == `IPF_ADDR_PINMAP)
               pinmap_reg <= pwdata & `IPF_PIN_MASK;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Packer: video pairs into double words
   // ----------------------------------------------------------------------------
   reg  [31:0] dw_reg,  dw_next;
   reg  [15:0] half_reg, half_next;
   reg         dw_sol_reg, dw_sol_next, dw_eol_reg, dw_eol_next;
   reg         dw_field_reg, dw_field_next, dw_vact_reg, dw_vact_next;
   reg         half_sol_reg, half_sol_next, flush_reg, flush_next;
   reg         dw_full_next, half_v_next, seen_reg, seen_next;
   reg  [1:0]  phase_reg, phase_next, pos_reg, pos_next;
   reg  [1:0]  phase_eff, pos_eff;
   reg         seen_eff, sub_fmt, comb_line, chroma_pair, drop;
   reg  [7:0]  b0, b1, b2, b3;
   wire        dw_take;
   wire        accept = ce && vid_valid && vid_ready;

   always @* begin
      dw_next = dw_reg;                half_next = half_reg;
      dw_sol_next = dw_sol_reg;        dw_eol_next = dw_eol_reg;
      dw_field_next = dw_field_reg;    dw_vact_next = dw_vact_reg;
      half_sol_next = half_sol_reg;    flush_next = flush_reg;
      dw_full_next = dw_full_reg && !dw_take;
      half_v_next = half_v_reg;        seen_next = seen_reg;
      phase_next = phase_reg;          pos_next = pos_reg;
      phase_eff = vid_sof ? 2'h0 : phase_reg;
      seen_eff  = vid_sof ? 1'b0 : seen_reg;
      pos_eff   = vid_sol ? 2'h0 : pos_reg;
      sub_fmt   = (horizontal_packing_select == `IPF_PACK_420) || (horizontal_packing_select == `IPF_PACK_410);
      // Reserved packing codes fall back to luma only, which never needs chroma.
      comb_line = sub_fmt ? (phase_eff == luma_only_line_count)
                          : (horizontal_packing_select <= `IPF_PACK_411);
      chroma_pair = comb_line && (((horizontal_packing_select == `IPF_PACK_411) ||
                    (horizontal_packing_select == `IPF_PACK_410)) ? !pos_eff[1] : 1'b1);
      drop = sub_fmt && !skip_leading_luma_lines && !comb_line && !seen_eff;
      b0 = clip8(chroma_pair ? vid_cb : vid_y0, code_range_limit_select);
      b1 = clip8(chroma_pair ? vid_y0 : vid_y1, code_range_limit_select);
      b2 = clip8(vid_cr, code_range_limit_select);
      b3 = clip8(vid_y1, code_range_limit_select);
      if (flush_reg && !dw_full_next) begin
         dw_next = {clip8(`IPF_BYTE_ZERO, code_range_limit_select),
                    clip8(`IPF_BYTE_ZERO, code_range_limit_select), half_reg};
         dw_sol_next = half_sol_reg;
         dw_eol_next = 1'b1;
         dw_full_next = 1'b1;
         half_v_next = 1'b0;
         flush_next = 1'b0;
      end else if (accept) begin
         pos_next = pos_eff + 2'h1;
         if (vid_eol) begin
            phase_next = (phase_eff == luma_only_line_count) ? 2'h0 : phase_eff + 2'h1;
            seen_next = seen_eff || comb_line;
         end else begin
            seen_next = seen_eff;
         end
         dw_field_next = vid_field;
         dw_vact_next = vid_vact;
         if (!drop) begin
            if (!half_v_reg) begin
               if (chroma_pair || vid_eol) begin
                  dw_next = chroma_pair ? {b3, b2, b1, b0}
                                        : {clip8(`IPF_BYTE_ZERO, code_range_limit_select),
                                           clip8(`IPF_BYTE_ZERO, code_range_limit_select), b1, b0};
                  dw_full_next = 1'b1;
                  dw_sol_next = vid_sol;
                  dw_eol_next = vid_eol;
               end else begin
                  half_next = {b1, b0};
                  half_v_next = 1'b1;
                  half_sol_next = vid_sol;
               end
            end else begin
               dw_next = {b1, b0, half_reg};
               dw_full_next = 1'b1;
               dw_sol_next = half_sol_reg;
               half_sol_next = 1'b0;
               if (chroma_pair) begin
                  half_next = {b3, b2};
                  dw_eol_next = 1'b0;
                  flush_next = vid_eol;
               end else begin
                  half_v_next = 1'b0;
                  dw_eol_next = vid_eol;
               end
            end
         end
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         dw_reg <= 32'h00000000;     half_reg <= 16'h0000;
         dw_sol_reg <= 1'b0;         dw_eol_reg <= 1'b0;
         dw_field_reg <= 1'b0;       dw_vact_reg <= 1'b0;
         half_sol_reg <= 1'b0;       flush_reg <= 1'b0;
         dw_full_reg <= 1'b0;        half_v_reg <= 1'b0;
         seen_reg <= 1'b0;           phase_reg <= 2'h0;
         pos_reg <= 2'h0;            vid_ready <= 1'b0;
      end else if (ce) begin
         dw_reg <= dw_next;          half_reg <= half_next;
         dw_sol_reg <= dw_sol_next;  dw_eol_reg <= dw_eol_next;
         dw_field_reg <= dw_field_next;
         dw_vact_reg <= dw_vact_next;
         half_sol_reg <= half_sol_next;
         flush_reg <= flush_next;
         dw_full_reg <= dw_full_next;
         half_v_reg <= half_v_next;
         seen_reg <= seen_next;      phase_reg <= phase_next;
         pos_reg <= pos_next;
         vid_ready <= !dw_full_next && !flush_next;
      end
   end

   // ----------------------------------------------------------------------------
   // Port clock selection and gate input synchronisers
   // ----------------------------------------------------------------------------
   reg  [2:0] clk_s1_reg, clk_s2_reg;
   reg        int_clk_reg, sel_q_reg, sel_lvl;

   always @* begin
      case (port_clk_select)
         `IPF_CSEL_INT: sel_lvl = int_clk_reg;
         `IPF_CSEL_DEC: sel_lvl = clk_s2_reg[0];
         `IPF_CSEL_XP:  sel_lvl = clk_s2_reg[1];
         default:       sel_lvl = clk_s2_reg[2];
      endcase
   end

   wire tick = ce && sel_lvl && !sel_q_reg;

   always @(posedge clk) begin
      if (!rst_n) begin
         clk_s1_reg <= 3'h0;         clk_s2_reg <= 3'h0;
         gate_s1_reg <= 1'b0;        gate_s2_reg <= 1'b0;
         int_clk_reg <= 1'b0;        sel_q_reg <= 1'b0;
      end else if (ce) begin
         clk_s1_reg <= {ext_clk_in, xport_clk_in, decoder_clk_in};
         clk_s2_reg <= clk_s1_reg;
         gate_s1_reg <= transfer_ready_gate_in;
         gate_s2_reg <= gate_s1_reg;
         int_clk_reg <= !int_clk_reg;
         sel_q_reg <= sel_lvl;
      end
   end

   // ----------------------------------------------------------------------------
   // Serializer, code insertion and arbitration
   // ----------------------------------------------------------------------------
   reg  [1:0] cidx_reg, bidx_reg;
   reg        eav_reg, src_txt_reg, line_active_reference_ev_reg, vref_ev_reg, qual_ev_reg;
   reg  [7:0] lo_reg, hi_reg;
   wire       want_txt = txt_valid && (arb != `IPF_ARB_VONLY);
   wire       want_vid = dw_full_reg && (arb != `IPF_ARB_TONLY);
   wire       pick_txt = want_txt && (!want_vid || (arb == `IPF_ARB_TFRST));
   wire       vid_last = wide_bus ? bidx_reg[1] : (bidx_reg == 2'h3);
   wire [7:0] cbyte = code_byte(eav_reg, src_txt_reg ? 1'b0 : dw_vact_reg, field_ev_reg,
                                src_txt_reg ? text_code_msb : !programming_page_select);
   wire [7:0] lead = (cidx_reg == 2'h0) ? `IPF_LEAD_FF : ((cidx_reg == 2'h3) ? cbyte : `IPF_BYTE_ZERO);
   wire       gate_ok = gate_s2_reg;
   assign dw_take = tick && gate_ok && (st_reg == ST_VDAT) && dw_full_reg && vid_last;

   always @(posedge clk) begin
      if (!rst_n) begin
         st_reg <= ST_IDLE;          cidx_reg <= 2'h0;
         bidx_reg <= 2'h0;           eav_reg <= 1'b0;
         src_txt_reg <= 1'b0;        sliced_reg <= 1'b0;
         field_ev_reg <= 1'b0;       line_active_reference_ev_reg <= 1'b0;
         vref_ev_reg <= 1'b0;        qual_ev_reg <= 1'b0;
         lo_reg <= `IPF_BYTE_ZERO;   hi_reg <= `IPF_BYTE_ZERO;
         txt_ready <= 1'b0;
      end else if (ce) begin
         txt_ready <= 1'b0;
         if (tick) begin
            qual_ev_reg <= 1'b0;
            lo_reg <= `IPF_BYTE_ZERO;
            hi_reg <= `IPF_BYTE_ZERO;
            if (gate_ok) begin
               case (st_reg)
                  ST_IDLE: begin
                     bidx_reg <= 2'h0;
                     cidx_reg <= 2'h0;
                     eav_reg <= 1'b0;
                     line_active_reference_ev_reg <= 1'b0;
                     if (pick_txt) begin
                        src_txt_reg <= 1'b1;
                        st_reg <= codes_en ? ST_CODE : ST_TDAT;
                        sliced_reg <= 1'b1;
                     end else if (want_vid) begin
                        src_txt_reg <= 1'b0;
                        field_ev_reg <= dw_field_reg;
                        vref_ev_reg <= dw_vact_reg;
                        st_reg <= (codes_en && dw_sol_reg) ? ST_CODE : ST_VDAT;
                        if (codes_en && dw_sol_reg)
                           sliced_reg <= 1'b0;
                     end
                  end
                  ST_CODE: begin
                     lo_reg <= lead;
                     hi_reg <= lead;
                     qual_ev_reg <= 1'b1;
                     // The line reference frames the video bytes only, so it stays low across every code.
                     line_active_reference_ev_reg <= 1'b0;
                     cidx_reg <= cidx_reg + 2'h1;
                     if (cidx_reg == 2'h3) begin
                        st_reg <= eav_reg ? ST_IDLE : (src_txt_reg ? ST_TDAT : ST_VDAT);
                     end
                  end
                  ST_VDAT: begin
                     if (dw_full_reg) begin
                        qual_ev_reg <= 1'b1;
                        line_active_reference_ev_reg <= 1'b1;
                        lo_reg <= dw_reg[{bidx_reg, 3'h0} +: 8];
                        hi_reg <= wide_bus ? dw_reg[{bidx_reg, 3'h0} + 5'h08 +: 8] : `IPF_BYTE_ZERO;
                        bidx_reg <= wide_bus ? bidx_reg + 2'h2 : bidx_reg + 2'h1;
                        if (vid_last && dw_eol_reg) begin
                           eav_reg <= 1'b1;
                           cidx_reg <= 2'h0;
                           st_reg <= codes_en ? ST_CODE : ST_IDLE;
                        end
                     end
                  end
                  default: begin
                     if (txt_valid) begin
                        qual_ev_reg <= 1'b1;
                        lo_reg <= txt_data;
                        txt_ready <= 1'b1;
                        if (txt_last) begin
                           eav_reg <= 1'b1;
                           cidx_reg <= 2'h0;
                           st_reg <= codes_en ? ST_CODE : ST_IDLE;
                        end
                     end
                  end
               endcase
            end
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Output pins
   // ----------------------------------------------------------------------------
   // Every pin lags the internal state by one clk so data, qualifier and clock stay aligned.
   wire [8:0] ev = {sliced_reg, dw_full_reg, !vid_ready, !dw_full_reg && !half_v_reg,
                    programming_page_select, qual_ev_reg, line_active_reference_ev_reg, vref_ev_reg, field_ev_reg};

   always @(posedge clk) begin
      if (!rst_n) begin
         port_clk_out <= 1'b0;       port_data <= `IPF_BYTE_ZERO;
         upper_byte_lane_pins <= `IPF_BYTE_ZERO;
         output_data_qualifier <= 1'b0;
         line_active_reference <= 1'b0;
         gp_pin0 <= 1'b0;            gp_pin1 <= 1'b0;
      end else if (ce) begin
         port_clk_out <= sel_q_reg && (!gate_clk_mode || qual_ev_reg);
         port_data <= lo_reg;
         upper_byte_lane_pins <= wide_bus ? hi_reg : `IPF_BYTE_ZERO;
         output_data_qualifier <= qual_ev_reg ^ pol[0];
         line_active_reference <= line_active_reference_ev_reg ^ pol[1];
         gp_pin0 <= ev_pick(pinmap_reg[`IPF_PIN_GP0_LSB +: 4], ev) ^ pol[2];
         gp_pin1 <= ev_pick(pinmap_reg[`IPF_PIN_GP1_LSB +: 4], ev) ^ pol[3];
      end
   end

endmodule // ipf_top

// ### ipf_regs.vh
// Purpose: Register map, field positions, reset values and codes of the image port output formatter.
// Assumes: APB byte addressing with 32-bit aligned registers.
// Notes:   Included by ipf_top.v only.
`ifndef IPF_REGS_VH
`define IPF_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define IPF_ADDR_CTRL     12'h000
`define IPF_ADDR_PINMAP   12'h004
`define IPF_ADDR_STATUS   12'h008

// ----------------------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------------------
`define IPF_CTRL_PACK_LSB   0
`define IPF_CTRL_LINES_LSB  3
`define IPF_CTRL_SKIP_BIT   5
`define IPF_CTRL_LIMIT_BIT  6
`define IPF_CTRL_WIDE_BIT   7
`define IPF_CTRL_CODES_BIT  8
`define IPF_CTRL_PAGE_BIT   9
`define IPF_CTRL_ARBLO_BIT  10
`define IPF_CTRL_ARBHI_BIT  11
`define IPF_CTRL_GATE_BIT   12
`define IPF_CTRL_CSEL_LSB   13
`define IPF_CTRL_TMSB_BIT   15
`define IPF_CTRL_MASK       32'h0000FFFF
`define IPF_CTRL_RST        32'h00000100
`define IPF_PIN_GP0_LSB     0
`define IPF_PIN_GP1_LSB     4
`define IPF_PIN_POL_LSB     8
`define IPF_PIN_MASK        32'h00000FFF
`define IPF_PIN_RST         32'h00000078

// ----------------------------------------------------------------------------
// Encodings and codes
// ----------------------------------------------------------------------------
`define IPF_PACK_422   3'h0
`define IPF_PACK_411   3'h1
`define IPF_PACK_420   3'h2
`define IPF_PACK_410   3'h3
`define IPF_CSEL_INT   2'h0
`define IPF_CSEL_DEC   2'h1
`define IPF_CSEL_XP    2'h2
`define IPF_ARB_VONLY  2'h0
`define IPF_ARB_TONLY  2'h2
`define IPF_ARB_TFRST  2'h3
`define IPF_EV_COUNT   9
`define IPF_LIM0_LO    8'h01
`define IPF_LIM0_HI    8'hFE
`define IPF_LIM1_LO    8'h08
`define IPF_LIM1_HI    8'hF7
`define IPF_LEAD_FF    8'hFF
`define IPF_BYTE_ZERO  8'h00
`define IPF_PORT_CLK_MAX_MHZ 33

`endif

// ### ipf_properties.sv
// Purpose: Port-level checks of ipf_top.
// Assumes: Pin polarities stay at their defaults.
// Notes:   Bound into ipf_top below.
`timescale 1ns/1ps
module ipf_properties (
   input wire        clk,
   input wire        rst_n,
   input wire        ce,
   input wire        psel,
   input wire        penable,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire        pslverr,
   input wire [7:0]  port_data,
   input wire [7:0]  upper_byte_lane_pins,
   input wire        output_data_qualifier,
   input wire        line_active_reference
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire q = output_data_qualifier;
   wire h = line_active_reference;
   sequence s_lead; q && port_data == 8'hFF; endsequence
   AST_IDLE: assert property (!q |-> port_data == 8'h00 && upper_byte_lane_pins == 8'h00) else $error("idle");
   AST_CLIP: assert property (q && h |-> port_data inside {[8'h01:8'hFE]}) else $error("clip");
   AST_SAV: assert property ($rose(q) |-> s_lead) else $error("sav lead");
   AST_EAV: assert property ($fell(h) |-> ##[0:40] s_lead) else $error("eav lead");
   AST_LINE_ACTIVE_REFERENCE: assert property ($rose(h) |-> q) else $error("line_active_reference");
   AST_BOOT: assert property ($rose(rst_n) |-> !q ##1 !q) else $error("boot");
   AST_ERR: assert property (psel && !penable && ce && paddr > 12'h008 |=> pslverr && prdata == 32'h0)
      else $error("unmapped");
   AST_CE: assert property (!ce |=> $stable(port_data) && $stable(q)) else $error("freeze");
endmodule // ipf_properties
bind ipf_top ipf_properties chk_u (.*);

// ### ipf_rx_model.sv
// Purpose: Capture side and port clock source beside the formatter.
// Assumes: Data is taken on the falling port clock edge.
// Notes:   The decoder clock runs free.
`timescale 1ns/1ps
module ipf_rx_model (
   input  wire       port_clk_out,
   input  wire       output_data_qualifier,
   input  wire [7:0] port_data,
   output reg        dec_clk
);
   logic [7:0] rx_q[$];
   initial begin
      dec_clk = 0;
      forever #160 dec_clk = ~dec_clk;
   end
   always @(negedge port_clk_out) if (output_data_qualifier === 1'b1) rx_q.push_back(port_data);
endmodule // ipf_rx_model

// ### image_port_output_formatter_bench.sv
// Purpose: Self-checking bench of ipf_top.
// Assumes: Two-pair 4:2:2 lines in 8-bit mode on the decoder clock.
// Notes:   The text path is left idle.
`timescale 1ns/1ps
module image_port_output_formatter_bench;
   logic        clk, rst_n, ce, psel, penable, pwrite, vv, sol, eol, gate, fld;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd;
   logic [7:0]  y0, y1, cb, cr, ex[16];
   int          n_fail, n_compared, cyc;
   wire  [31:0] prdata;
   wire         pready, pslverr, rdy, pclk, qual, dclk, gp0, gp1;
   wire  [7:0]  pd;
   ipf_top dut_u (.clk, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .vid_valid(vv), .vid_ready(rdy), .vid_y0(y0), .vid_y1(y1), .vid_cb(cb), .vid_cr(cr), .vid_sol(sol),
      .vid_eol(eol), .vid_sof(sol), .vid_field(fld), .vid_vact(1'b1), .txt_valid(1'b0), .txt_data(y0),
      .txt_last(1'b0), .txt_ready(), .decoder_clk_in(dclk), .xport_clk_in(dclk), .ext_clk_in(dclk),
      .transfer_ready_gate_in(gate), .port_clk_out(pclk), .port_data(pd), .upper_byte_lane_pins(),
      .output_data_qualifier(qual), .line_active_reference(), .gp_pin0(gp0), .gp_pin1(gp1));
   ipf_rx_model rx (.port_clk_out(pclk), .output_data_qualifier(qual), .port_data(pd), .dec_clk(dclk));
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         n_fail++;
         $display("[FAIL] %0t %h %h", $time, s, e);
      end
   endtask
   task wrap_up;
      if (n_fail == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk) penable <= 1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      {psel, penable} <= 2'b00;
   endtask
   task pair(input logic [7:0] a, b, c, d, input logic s, e);
      @(posedge clk) {vv, cb, y0, cr, y1, sol, eol} <= {1'b1, a, b, c, d, s, e};
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      vv <= 0;
   endtask
   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         wrap_up;
      end
   end
   initial begin
      {ce, gate, cyc} = 34'h3_0000_0000;
      {rst_n, psel, penable, pwrite, vv, sol, eol, fld, paddr, pwdata, y0, y1, cb, cr} = 0;
      repeat (10) @(posedge clk);
      rst_n <= 1;
      apb(0, 12'h000, 0);
      chk(rd, 32'h100);
      apb(0, 12'h004, 0);
      chk(rd, 32'h78);
      apb(0, 12'h00C, 0);
      chk({rd[30:0], pslverr}, 32'h1);
      for (int k = 0; k < 2; k++) begin
         if (k) begin
            rst_n <= 0;
            repeat (10) @(posedge clk);
            rst_n <= 1;
            apb(0, 12'h000, 0);
            chk(rd, 32'h100);
         end
         apb(1, 12'h000, 32'h2100 | (k << 6));
         fld <= k;
         pair(8'h00, 8'hFF, 8'h10, 8'h20, 1, 0);
         {gate, ce} <= {k == 0, 1'b0};
         @(posedge clk) ce <= 1;
         repeat (30) @(posedge clk);
         chk({gp1, gp0}, 32'h2);
         gate <= 1;
         pair(8'h30, 8'h40, 8'h50, 8'h60, 0, 1);
         for (int i = 0; i < 600 && rx.rx_q.size() < 16; i++) @(posedge clk);
         ex = '{8'hFF, 0, 0, k ? 8'hC7 : 8'h80, k ? 8'h08 : 8'h01, k ? 8'hF7 : 8'hFE, 8'h10, 8'h20,
                8'h30, 8'h40, 8'h50, 8'h60, 8'hFF, 0, 0, k ? 8'hDA : 8'h9D};
         for (int i = 0; i < 16; i++) chk(rx.rx_q[i], ex[i]);
         chk({gp1, gp0}, 32'h0);
         rx.rx_q.delete();
      end
      wrap_up;
   end
endmodule // image_port_output_formatter_bench
